// file: bench/qde_event_bank_chk.sv
/*
  Port checker for the quick event bank.
  Assumes one clock and that i_ce stays high.
*/
`timescale 1ns/100ps
module qde_event_bank_chk
  import qde_pkg::*;
(
  input wire logic                       i_clk_sys,         // System clock
  input wire logic                       i_rst_n,           // Reset, active low
  input wire logic [qde_pkg::QDE_AW-1:0] i_avs_address,     // Byte address
  input wire logic                       i_avs_read,        // Read request
  input wire logic                       i_avs_write,       // Write request
  input wire logic [qde_pkg::QDE_DW-1:0] o_avs_readdata,    // Read data
  input wire logic                       o_avs_waitrequest, // Stall
  input wire logic                       o_tr_valid,        // Request offered
  input wire logic [3:0]                 o_tr_chan,         // One-hot channel
  input wire logic                       i_tr_ready,        // Submitted
  input wire logic                       o_irq              // Interrupt
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);
  // Outputs quiet on leaving reset, bus answers in one cycle for one cycle
  a_reset_quiet: assert property ($rose(i_rst_n) |-> !o_tr_valid && !o_irq
    && o_avs_waitrequest && o_tr_chan == 4'h0) else $error("outputs not reset");
  a_bus_answer: assert property ($rose(i_avs_read || i_avs_write) |=> !o_avs_waitrequest)
    else $error("bus answer late");
  a_bus_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low too long");
  // Offer is one-hot, stands until submitted outside bus writes, drops after submission
  a_offer_onehot: assert property (o_tr_valid |-> $onehot(o_tr_chan))
    else $error("offer not one-hot");
  a_offer_holds: assert property (o_tr_valid && !i_tr_ready && !i_avs_write
    |=> o_tr_valid && $stable(o_tr_chan)) else $error("offer withdrawn");
  a_take_clears: assert property (o_tr_valid && i_tr_ready |=> !o_tr_valid)
    else $error("offer stays after submission");
  // Read data rules of the flag, enable and set/clear registers
  a_flags_upper: assert property (!o_avs_waitrequest && i_avs_read
    && (i_avs_address == QDE_OFS_FLAGS || i_avs_address == QDE_OFS_ENABLES)
    |-> o_avs_readdata[31:4] == 28'h000_0000) else $error("upper bits not zero");
  a_setclr_zero: assert property (!o_avs_waitrequest && i_avs_read
    && (i_avs_address == QDE_OFS_EN_CLR || i_avs_address == QDE_OFS_EN_SET)
    |-> o_avs_readdata == 32'h0000_0000) else $error("set/clear read not zero");
endmodule : qde_event_bank_chk
bind qde_event_bank qde_event_bank_chk chk_u (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .o_tr_valid(o_tr_valid), .o_tr_chan(o_tr_chan), .i_tr_ready(i_tr_ready), .o_irq(o_irq));

// file: bench/qde_tc_model.sv
/*
  Transfer controller stand-in: accepts an offered request after a set
  number of stall cycles. Assumes it shares the block's clock and reset.
*/
`timescale 1ns/100ps
module qde_tc_model (
  input  wire logic       i_clk_sys, // System clock
  input  wire logic       i_rst_n,   // Synchronous reset, active low
  input  wire logic       i_valid,   // Request offered
  input  wire logic [4:0] i_dly,     // Stall cycles before accepting, minus one
  output logic            o_ready    // Request submitted
);
  logic [4:0] wait_q;
  // Count stall cycles, accept for one cycle, then wait for a new offer
  always_ff @(posedge i_clk_sys)
    if (!i_rst_n || !i_valid || o_ready)
    begin
      wait_q  <= 5'h0;
      o_ready <= 1'b0;
    end
    else
    begin
      wait_q  <= wait_q + 5'h1;
      o_ready <= (wait_q >= i_dly);
    end
endmodule : qde_tc_model

// file: bench/tb.sv
/*
  Self-checking bench for the quick event bank with a transfer controller
  model. Assumes the design package and the checker are compiled first.
*/
`timescale 1ns/100ps
module tb;
  import qde_pkg::*;
  logic        clk = 0, rst_n = 0, rd = 0, wr = 0, dwr = 0, lwr = 0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, q;
  logic [8:0]  entry = 9'h000;
  logic [2:0]  word = 3'h0;
  logic [4:0]  dly = 5'h00;
  logic [31:0] rdat;
  logic [3:0]  tr_chan;
  logic        waitreq, tr_valid, tr_ready, irq;
  int          miscompares = 0, samples_checked = 0;
  always #2.5 clk = ~clk;
  qde_event_bank dut_u (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(1'b1),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .i_avs_byteenable(4'hF), .o_avs_readdata(rdat), .o_avs_waitrequest(waitreq),
    .i_desc_wr(dwr), .i_desc_entry(entry), .i_desc_word(word), .i_link_wr(lwr),
    .i_link_entry(entry), .i_link_word(word), .o_tr_valid(tr_valid),
    .o_tr_chan(tr_chan), .i_tr_ready(tr_ready), .o_irq(irq));
  qde_tc_model tc_u (.i_clk_sys(clk), .i_rst_n(rst_n), .i_valid(tr_valid),
    .i_dly(dly), .o_ready(tr_ready));
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out
  task automatic fail_out;
    miscompares++;
    close_out();
  endtask : fail_out
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One bus access: hold until waitrequest is sampled low, then release
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do
    begin
      @(posedge clk);
      n++;
      if (n > 50)
        fail_out();
    end while (waitreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(q, exp);
  endtask : rd_chk
  task automatic wait_v(input logic v);
    int n;
    n = 0;
    while (tr_valid !== v)
    begin
      @(posedge clk);
      n++;
      if (n > 200)
        fail_out();
    end
  endtask : wait_v
  // Pulse a descriptor or link write of word w in the entry mapped to ch
  task automatic trig(input int ch, input logic lnk, input logic [2:0] w);
    lwr <= lnk;
    dwr <= !lnk;
    entry <= 9'(16 + ch);
    word <= w;
    @(posedge clk);
    lwr <= 1'b0;
    dwr <= 1'b0;
    entry <= ~entry;
  endtask : trig
  task automatic t_regs;
    rd_chk(QDE_OFS_FLAGS, 32'h0000_0000);
    rd_chk(QDE_OFS_ENABLES, 32'h0000_0000);
    rd_chk(8'h3C, QDE_UNMAPPED);
    bus(1'b1, QDE_OFS_ENABLES, 32'h0000_000F);
    rd_chk(QDE_OFS_ENABLES, 32'h0000_0000);
    bus(1'b1, QDE_OFS_EN_SET, 32'h0000_0005);
    rd_chk(QDE_OFS_ENABLES, 32'h0000_0005);
    bus(1'b1, QDE_OFS_EN_SET, 32'hFFFF_FFFA);
    rd_chk(QDE_OFS_ENABLES, 32'h0000_000F);
    bus(1'b1, QDE_OFS_EN_CLR, 32'h0000_0009);
    rd_chk(QDE_OFS_EN_CLR, 32'h0000_0000);
    rd_chk(QDE_OFS_EN_SET, 32'h0000_0000);
    rd_chk(QDE_OFS_ENABLES, 32'h0000_0006);
    for (int ch = 0; ch < 4; ch++)
      bus(1'b1, QDE_OFS_MAP0 + 8'(4 * ch), 32'((16 + ch) << 5 | 7 << 2));
  endtask : t_regs
  // Disabled channel ignored; repeat trigger missed; interrupt on the miss
  task automatic t_miss;
    trig(0, 1'b0, 3'h7);
    repeat (4) @(posedge clk);
    check(tr_valid, 1'b0);
    dly <= 5'h08;
    trig(1, 1'b0, 3'h7);
    wait_v(1'b1);
    check(tr_chan, 4'h2);
    rd_chk(QDE_OFS_FLAGS, 32'h0000_0002);
    trig(1, 1'b0, 3'h7);
    rd_chk(QDE_OFS_MISSED, 32'h0000_0002);
    bus(1'b1, QDE_OFS_IRQ_EN, 32'h0000_0002);
    repeat (2) @(posedge clk);
    check(irq, 1'b1);
    bus(1'b1, QDE_OFS_IRQ_EN, 32'h0000_0000);
    repeat (2) @(posedge clk);
    check(irq, 1'b0);
    bus(1'b1, QDE_OFS_IRQ_EN, 32'h0000_0002);
    bus(1'b1, QDE_OFS_IRQ_CLR, 32'h0000_0002);
    repeat (2) @(posedge clk);
    check(irq, 1'b0);
    wait_v(1'b0);
    rd_chk(QDE_OFS_FLAGS, 32'h0000_0000);
    bus(1'b1, QDE_OFS_MISS_CLR, 32'h0000_0002);
  endtask : t_miss
  // Link update must hit the mapped trigger word
  task automatic t_link;
    dly <= 5'h00;
    trig(2, 1'b1, 3'h3);
    repeat (4) @(posedge clk);
    check(tr_valid, 1'b0);
    trig(2, 1'b1, 3'h7);
    wait_v(1'b1);
    check(tr_chan, 4'h4);
    wait_v(1'b0);
  endtask : t_link
  // Trigger lands on the submission edge: flag stays set, miss recorded
  task automatic t_coincide;
    dly <= 5'h03;
    trig(1, 1'b0, 3'h7);
    wait_v(1'b1);
    repeat (3) @(posedge clk);
    trig(1, 1'b0, 3'h7);
    rd_chk(QDE_OFS_FLAGS, 32'h0000_0002);
    rd_chk(QDE_OFS_MISSED, 32'h0000_0002);
    wait_v(1'b0);
  endtask : t_coincide
  // Secondary clear withdraws a stalled offer and clears its flag
  task automatic t_sec_clr;
    bus(1'b1, QDE_OFS_EN_SET, 32'h0000_0008);
    dly <= 5'h1F;
    trig(3, 1'b0, 3'h7);
    wait_v(1'b1);
    check(tr_chan, 4'h8);
    bus(1'b1, QDE_OFS_SEC_CLR, 32'h0000_0008);
    rd_chk(QDE_OFS_FLAGS, 32'h0000_0000);
    rd_chk(QDE_OFS_SECOND, 32'h0000_0000);
    check(tr_valid, 1'b0);
  endtask : t_sec_clr
  // Trigger held across an enable-set access uses the old enable; later ones latch
  task automatic t_en_edge;
    int n;
    n = 0;
    addr <= QDE_OFS_EN_SET;
    wdata <= 32'h0000_0001;
    wr <= 1'b1;
    dwr <= 1'b1;
    entry <= 9'h010;
    word <= 3'h7;
    do
    begin
      @(posedge clk);
      n++;
      if (n > 50)
        fail_out();
    end while (waitreq !== 1'b0);
    wr <= 1'b0;
    dwr <= 1'b0;
    entry <= ~entry;
    @(posedge clk);
    rd_chk(QDE_OFS_FLAGS, 32'h0000_0000);
    rd_chk(QDE_OFS_ENABLES, 32'h0000_000F);
    trig(0, 1'b0, 3'h7);
    rd_chk(QDE_OFS_FLAGS, 32'h0000_0001);
    wait_v(1'b0);
  endtask : t_en_edge
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_miss();
    t_link();
    t_coincide();
    t_sec_clr();
    t_en_edge();
    close_out();
  end
endmodule : tb

// file: common/qde_pkg.sv
/*
  Package for the quick DMA event and enable block: register offsets,
  field widths, reset values and the descriptor map layout.
  Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
*/
package qde_pkg;

  localparam int unsigned QDE_NCH        = 4;          // Quick channels
  localparam int unsigned QDE_AW         = 8;          // Register byte address width
  localparam int unsigned QDE_DW         = 32;         // Bus data width
  localparam int unsigned QDE_DESC_AW    = 9;          // Descriptor entry index width
  localparam int unsigned QDE_WORD_W     = 3;          // Word-in-entry index width

  // Register byte offsets
  localparam logic [7:0] QDE_OFS_FLAGS     = 8'h00;    // quick_event_flags, RO
  localparam logic [7:0] QDE_OFS_ENABLES   = 8'h04;    // quick_event_enables, RO
  localparam logic [7:0] QDE_OFS_EN_CLR    = 8'h08;    // quick_enable_clear, WO
  localparam logic [7:0] QDE_OFS_EN_SET    = 8'h0C;    // quick_enable_set, WO
  localparam logic [7:0] QDE_OFS_MISSED    = 8'h10;    // quick_missed_event_flags, RO
  localparam logic [7:0] QDE_OFS_MISS_CLR  = 8'h14;    // Missed-event clear, W1C
  localparam logic [7:0] QDE_OFS_SECOND    = 8'h18;    // quick_secondary_event_flags, RO
  localparam logic [7:0] QDE_OFS_SEC_CLR   = 8'h1C;    // quick_secondary_event_clear, W1C
  localparam logic [7:0] QDE_OFS_IRQ_STAT  = 8'h20;    // Interrupt status, RO
  localparam logic [7:0] QDE_OFS_IRQ_EN    = 8'h24;    // Interrupt enable, RW
  localparam logic [7:0] QDE_OFS_IRQ_CLR   = 8'h28;    // Interrupt clear, WO
  localparam logic [7:0] QDE_OFS_MAP0      = 8'h40;    // quick_channel_descriptor_map 0..3

  // Map register fields: entry index at [13:5], trigger word at [4:2]
  localparam int unsigned QDE_MAP_ENTRY_LSB = 5;
  localparam int unsigned QDE_MAP_WORD_LSB  = 2;

  // Reset values
  localparam logic [3:0]  QDE_RST_CH   = 4'h0;
  localparam logic [31:0] QDE_RST_WORD = 32'h0000_0000;
  localparam logic [31:0] QDE_UNMAPPED = 32'hDEAD_BEEF; // Read data at unmapped offsets

endpackage : qde_pkg

// file: common/qde_req_if.sv
/*
  Interface between the event block and its request arbiter: pending
  flags in, one-hot grant back. Assumes a single clock domain.
*/
`timescale 1ns/100ps
interface qde_req_if #(parameter int unsigned NCH = 4);
  logic [NCH-1:0] pend;    // Channels competing for submission
  logic           take;    // Event block accepts the grant this cycle
  logic [NCH-1:0] grant;   // One-hot winner
  modport evt (output pend, output take, input grant);
  modport arb (input pend, input take, output grant);
endinterface : qde_req_if

// file: src/qde_arb.sv
/*
  Round-robin picker over pending quick channels.
  Assumes pend is stable in the cycle it is sampled; grant is combinational, only the last winner is registered.
*/
`timescale 1ns/100ps
module qde_arb #(
  parameter int unsigned NCH = 4
) (
  input  wire logic i_clk_sys,   // System clock
  input  wire logic i_rst_n,     // Synchronous reset, active low
  input  wire logic i_ce,        // Clock enable
  qde_req_if.arb    req          // Pending flags and grant
);
  logic [NCH-1:0] last_q;        // Last winner, for rotation

  // Pick the first pending channel after the previous winner
  always_comb
  begin
    logic found;
    int   idx;
    found     = 1'b0;
    idx       = 0;
    req.grant = '0;
    for (int k = 1; k <= NCH; k++)
    begin
      idx = 0;
      for (int b = 0; b < NCH; b++)
        if (last_q[b])
          idx = (b + k) % NCH;
      if (!found && req.pend[idx])
      begin
        req.grant[idx] = 1'b1;
        found          = 1'b1;
      end
    end
  end

  // Remember the winner on each accepted grant
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      last_q <= {1'b1, {(NCH-1){1'b0}}};
    else if (i_ce && req.take && |req.grant)
      last_q <= req.grant;
  end
endmodule : qde_arb

// file: src/qde_event_bank.sv
/*
  Quick DMA event latching and per-channel enables, with an Avalon-MM
  register slave, missed/secondary event tracking and an interrupt.
  Assumes the trigger and link-update strobes come from logic on i_clk_sys,
  and that the transfer controller handshakes i_tr_ready on o_tr_valid.
*/
// Operation
// - Bus write to a channel's mapped trigger word sets its event flag.
// - Link update hitting a channel's mapped trigger word also sets its flag.
// - Triggers on disabled channels are ignored; flags latch only when enabled.
// - A set flag makes the channel a candidate for request submission.
// - Set flags compete in the arbiter with other pending events.
// - Same-cycle set and hardware clear leaves the flag set.
// - Coincident set/clear on an already set flag also records a miss.
// - Coincident set/clear on a clear flag leaves it set and queued.
// - Hardware clears a flag only when its request is submitted.
// - A trigger on an already set flag is dropped and marks a miss.
// - Flag register is read-only, bits 3-0, upper bits zero, resets zero.
// - Enable register is read-only, bits 3-0, one means triggers latch.
// - Writes to the enable register are ignored; use set/clear registers.
// - Writing one to enable-clear bit clears that enable; zero does nothing.
// - Writing one to enable-set bit sets that enable; zero does nothing.
// - Writing one to secondary-clear clears that flag and secondary bit.
// - While secondary bit is set, no further events on that channel prioritised.
`timescale 1ns/100ps
module qde_event_bank
  import qde_pkg::*;
#(
  parameter int unsigned NCH = qde_pkg::QDE_NCH
) (
  input  wire logic                          i_clk_sys,     // 200 MHz system clock
  input  wire logic                          i_rst_n,       // Synchronous reset, active low
  input  wire logic                          i_ce,          // Clock enable, freezes state
  // Avalon-MM slave
  input  wire logic [qde_pkg::QDE_AW-1:0]    i_avs_address, // Byte address
  input  wire logic                          i_avs_read,    // Read request
  input  wire logic                          i_avs_write,   // Write request
  input  wire logic [qde_pkg::QDE_DW-1:0]    i_avs_writedata, // Write data
  input  wire logic [3:0]                    i_avs_byteenable, // Byte lanes
  output logic [qde_pkg::QDE_DW-1:0]         o_avs_readdata, // Read data
  output logic                               o_avs_waitrequest, // Stall
  // Descriptor memory write observers (any master, and link update)
  input  wire logic                          i_desc_wr,     // Master wrote a descriptor word
  input  wire logic [qde_pkg::QDE_DESC_AW-1:0] i_desc_entry, // Entry written
  input  wire logic [qde_pkg::QDE_WORD_W-1:0]  i_desc_word,  // Word within entry
  input  wire logic                          i_link_wr,     // Link update wrote a word
  input  wire logic [qde_pkg::QDE_DESC_AW-1:0] i_link_entry, // Entry written by link
  input  wire logic [qde_pkg::QDE_WORD_W-1:0]  i_link_word,  // Word written by link
  // Transfer request toward the transfer controller
  output logic                               o_tr_valid,    // Request offered
  output logic [NCH-1:0]                     o_tr_chan,     // One-hot channel
  input  wire logic                          i_tr_ready,    // Request submitted
  output logic                               o_irq          // Level interrupt
);

  qde_req_if #(.NCH(NCH)) req ();

  logic [NCH-1:0] flags_q;       // quick_event_flags
  logic [NCH-1:0] enables_q;     // quick_event_enables
  logic [NCH-1:0] missed_q;      // quick_missed_event_flags
  logic [NCH-1:0] second_q;      // quick_secondary_event_flags
  logic [NCH-1:0] irq_stat_q;    // Sticky: bit n = miss on channel n
  logic [NCH-1:0] irq_en_q;      // Interrupt enable
  logic [31:0]    map_q [NCH];   // quick_channel_descriptor_map
  logic [NCH-1:0] trig;          // Raw triggers this cycle
  logic [NCH-1:0] trig_ok;       // Triggers on enabled channels
  logic [NCH-1:0] hw_clr;        // Flag cleared by submission
  logic [NCH-1:0] sw_clr;        // Flag cleared by secondary-clear write
  logic [NCH-1:0] miss_set;      // Lost events this cycle
  logic           wr_acc;        // Write accepted this cycle
  logic           rd_acc;        // Read accepted this cycle
  logic [31:0]    wmask;         // Byte-enable mask
  logic [31:0]    wd_m;          // Masked write data
  logic           busy_q;        // Answer phase of the slave
  logic [NCH-1:0] tr_chan_q;     // Channel being offered
  logic           tr_valid_q;    // Offer in progress

  // Arbiter over pending, non-blocked flags
  qde_arb #(.NCH(NCH)) u_arb (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .req       (req)
  );

  // Byte-enable mask and masked data
  always_comb
  begin
    for (int b = 0; b < 4; b++)
      wmask[8*b +: 8] = {8{i_avs_byteenable[b]}};
    wd_m = i_avs_writedata & wmask;
  end

  // Slave takes each request after one wait cycle
  assign wr_acc = i_ce && i_avs_write && busy_q;
  assign rd_acc = i_ce && i_avs_read && busy_q;

  // Trigger match per channel, against map entry and trigger word
  generate
    for (genvar n = 0; n < NCH; n++)
    begin : g_trig
      logic [QDE_DESC_AW-1:0] ent;
      logic [QDE_WORD_W-1:0]  wrd;
      assign ent = map_q[n][QDE_MAP_ENTRY_LSB +: QDE_DESC_AW];
      assign wrd = map_q[n][QDE_MAP_WORD_LSB +: QDE_WORD_W];
      assign trig[n] = (i_desc_wr && i_desc_entry == ent && i_desc_word == wrd)
                     | (i_link_wr && i_link_entry == ent && i_link_word == wrd);
    end
  endgenerate

  // Pre-write enables gate this cycle's triggers
  assign trig_ok  = trig & enables_q;
  assign hw_clr   = (tr_valid_q && i_tr_ready) ? tr_chan_q : '0;
  assign sw_clr   = (wr_acc && i_avs_address == QDE_OFS_SEC_CLR) ? wd_m[NCH-1:0] : '0;
  // Already-set flag loses the new event, clear or not
  assign miss_set = trig_ok & flags_q;

  // Pending set: flags not held back by a queued secondary event
  assign req.pend = flags_q & ~second_q & {NCH{~tr_valid_q}};
  assign req.take = i_ce && !tr_valid_q;

  // Event flags: set wins over hardware and software clear
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      flags_q <= QDE_RST_CH;
    else if (i_ce)
      flags_q <= (flags_q & ~hw_clr & ~sw_clr) | trig_ok;
  end

  // Enables change only via set and clear registers
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      enables_q <= QDE_RST_CH;
    else if (wr_acc && i_avs_address == QDE_OFS_EN_CLR)
      enables_q <= enables_q & ~wd_m[NCH-1:0];
    else if (wr_acc && i_avs_address == QDE_OFS_EN_SET)
      enables_q <= enables_q | wd_m[NCH-1:0];
  end

  // Missed events: hardware set beats software clear
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      missed_q <= QDE_RST_CH;
    else if (i_ce)
    begin
      if (wr_acc && i_avs_address == QDE_OFS_MISS_CLR)
        missed_q <= (missed_q & ~wd_m[NCH-1:0]) | miss_set;
      else
        missed_q <= missed_q | miss_set;
    end
  end

  // Secondary flags: set on grant, cleared on submission or by software
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      second_q <= QDE_RST_CH;
    else if (i_ce)
      second_q <= (second_q & ~hw_clr & ~sw_clr)
                | ((req.take) ? req.grant : '0);
  end

  // Request offer to the transfer controller
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      tr_valid_q <= 1'b0;
      tr_chan_q  <= QDE_RST_CH;
    end
    else if (i_ce)
    begin
      // Withdraw in the cycle the software clear lands, unless a trigger re-sets the flag
      if (tr_valid_q && (i_tr_ready || !(|(tr_chan_q & ((flags_q & ~sw_clr) | trig_ok)))))
        tr_valid_q <= 1'b0;                                   // Done, or withdrawn
      else if (!tr_valid_q && |req.grant)
      begin
        tr_valid_q <= 1'b1;
        tr_chan_q  <= req.grant;
      end
    end
  end

  // Interrupt status, enable and map registers
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      irq_stat_q <= QDE_RST_CH;
      irq_en_q   <= QDE_RST_CH;
      for (int n = 0; n < NCH; n++)
        map_q[n] <= QDE_RST_WORD;
    end
    else if (i_ce)
    begin
      if (wr_acc && i_avs_address == QDE_OFS_IRQ_CLR)
        irq_stat_q <= (irq_stat_q & ~wd_m[NCH-1:0]) | miss_set;
      else
        irq_stat_q <= irq_stat_q | miss_set;
      if (wr_acc && i_avs_address == QDE_OFS_IRQ_EN)
        irq_en_q <= wd_m[NCH-1:0];
      for (int n = 0; n < NCH; n++)
        if (wr_acc && i_avs_address == QDE_OFS_MAP0 + 8'(4 * n))
          map_q[n] <= (map_q[n] & ~wmask) | wd_m;
    end
  end

  // Slave handshake: one wait cycle, then accept
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      busy_q <= 1'b0;
    else if (i_ce)
      busy_q <= (i_avs_read || i_avs_write) && !busy_q;
  end

  // Read data, registered, valid at the accepting edge
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      o_avs_readdata <= QDE_RST_WORD;
    else if (i_ce && i_avs_read && !busy_q)
    begin
      o_avs_readdata <= QDE_RST_WORD;
      unique case (i_avs_address)
        QDE_OFS_FLAGS:    o_avs_readdata[NCH-1:0] <= flags_q;
        QDE_OFS_ENABLES:  o_avs_readdata[NCH-1:0] <= enables_q;
        QDE_OFS_EN_CLR,
        QDE_OFS_EN_SET,
        QDE_OFS_MISS_CLR,
        QDE_OFS_SEC_CLR,
        QDE_OFS_IRQ_CLR:  o_avs_readdata <= QDE_RST_WORD;
        QDE_OFS_MISSED:   o_avs_readdata[NCH-1:0] <= missed_q;
        QDE_OFS_SECOND:   o_avs_readdata[NCH-1:0] <= second_q;
        QDE_OFS_IRQ_STAT: o_avs_readdata[NCH-1:0] <= irq_stat_q;
        QDE_OFS_IRQ_EN:   o_avs_readdata[NCH-1:0] <= irq_en_q;
        default:
        begin
          o_avs_readdata <= QDE_UNMAPPED;
          for (int n = 0; n < NCH; n++)
            if (i_avs_address == QDE_OFS_MAP0 + 8'(4 * n))
              o_avs_readdata <= map_q[n];
        end
      endcase
    end
  end

  // Registered outputs
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      o_avs_waitrequest <= 1'b1;
      o_irq             <= 1'b0;
    end
    else if (i_ce)
    begin
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) && !busy_q);
      o_irq             <= |(irq_stat_q & irq_en_q);
    end
  end

  assign o_tr_valid = tr_valid_q;
  assign o_tr_chan  = tr_chan_q;

endmodule : qde_event_bank
